//--- verilog/lmoc_consts.svh
// Constants of the LCD multiplex output control block: offsets, fields, resets, timing
`ifndef LMOC_CONSTS_SVH
`define LMOC_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LMOC_ADR_MODE 8'h00
`define LMOC_ADR_BANK 8'h04
`define LMOC_ADR_STAT 8'h08
`define LMOC_ADR_ROW_BASE 8'h10
`define LMOC_ADR_ROW_LAST 8'h2c
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define LMOC_MODE_EN_BIT 0
`define LMOC_MODE_BIAS_BIT 1
`define LMOC_MODE_DRV_LSB 2
`define LMOC_MODE_RST 4'h0
`define LMOC_BANK_OUT_BIT 0
`define LMOC_BANK_RST 1'h0
// ----------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------
`define LMOC_SEGS 40
`define LMOC_BPS 4
`define LMOC_CLK_MHZ 250
`define LMOC_PHASE_NS 2000
`define LMOC_PHASE_CYC ((`LMOC_PHASE_NS * `LMOC_CLK_MHZ) / 1000)
`endif

//--- verilog/lmoc_pkg.sv
// Types shared by the LCD multiplex output control block
package lmoc_pkg;
    // Drive mode field codes
    typedef enum logic [1:0] {
        LMOC_DRV_STATIC = 2'h0,
        LMOC_DRV_MUX2 = 2'h1,
        LMOC_DRV_MUX3 = 2'h2,
        LMOC_DRV_MUX4 = 2'h3
    } lmoc_drive_t;
    // Divider tap index: 0 ground, 1 lower tap, 2 upper tap, 3 full LCD supply
    typedef logic [1:0] lmoc_level_t;
    // Phase sequencer states, one-hot
    typedef enum logic [1:0] {
        LMOC_ST_OFF = 2'b01,
        LMOC_ST_RUN = 2'b10
    } lmoc_seq_state_t;
endpackage : lmoc_pkg

//--- verilog/lmoc_seq_if.sv
// Carrier between the output control core and its phase sequencer
`timescale 1ns/1ps
interface lmoc_seq_if;
    logic enable;        // Display enabled
    logic [2:0] nphase;  // Active backplanes, 1 to 4
    logic [1:0] phase;   // Current multiplex phase
    logic pol;           // Frame polarity
    logic start;         // One-cycle pulse at each phase start
    modport seq (input enable, input nphase, output phase, output pol, output start);
    modport ctl (output enable, output nphase, input phase, input pol, input start);
endinterface : lmoc_seq_if

//--- verilog/lmoc_phase_seq.sv
// Multiplex phase and frame polarity sequencer
`timescale 1ns/1ps
`include "lmoc_consts.svh"
module lmoc_phase_seq #(
    parameter int PHASE_CYCLES = `LMOC_PHASE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    lmoc_seq_if.seq sq
);
    import lmoc_pkg::*;
    localparam int CW = $clog2(PHASE_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(PHASE_CYCLES - 1);

    if (PHASE_CYCLES < 1) begin : g_chk
        $error("PHASE_CYCLES must be at least one");
    end

    lmoc_seq_state_t state_reg, state_next;  // Running or parked
    logic [CW-1:0] cnt_reg, cnt_next;       // Cycles within phase
    logic [1:0] phase_reg, phase_next;      // Phase index
    logic pol_reg, pol_next;                // Frame polarity
    logic start_reg, start_next;            // Phase start pulse
    logic [2:0] nph_reg, nph_next;          // Phase count in use
    logic [1:0] last_phase;                 // Final phase of a frame

    assign last_phase = 2'(nph_reg - 3'h1);
    assign sq.phase = phase_reg;
    assign sq.pol = pol_reg;
    assign sq.start = start_reg;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        phase_next = phase_reg;
        pol_next = pol_reg;
        start_next = 1'b0;
        nph_next = sq.nphase;
        case (state_reg)
            LMOC_ST_OFF: begin
                // Start a fresh frame at phase 0
                if (sq.enable) begin
                    state_next = LMOC_ST_RUN;
                    cnt_next = '0;
                    phase_next = 2'h0;
                    start_next = 1'b1;
                end
            end
            LMOC_ST_RUN: begin
                // Mode change or disable restarts the sequence
                if (!sq.enable || sq.nphase != nph_reg) begin
                    state_next = LMOC_ST_OFF;
                    cnt_next = '0;
                    phase_next = 2'h0;
                    // Every restart begins with the even frame
                    pol_next = 1'b0;
                end else if (cnt_reg == CNT_LAST) begin
                    cnt_next = '0;
                    start_next = 1'b1;
                    if (phase_reg == last_phase) begin
                        phase_next = 2'h0;
                        pol_next = ~pol_reg;
                    end else begin
                        phase_next = 2'(phase_reg + 2'h1);
                    end
                end else begin
                    cnt_next = CW'(cnt_reg + 1'b1);
                end
            end
            default: begin
                state_next = LMOC_ST_OFF;
            end
        endcase
    end

    // Register stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= LMOC_ST_OFF;
            cnt_reg <= '0;
            phase_reg <= 2'h0;
            pol_reg <= 1'b0;
            start_reg <= 1'b0;
            nph_reg <= 3'h1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
            pol_reg <= pol_next;
            start_reg <= start_next;
            nph_reg <= nph_next;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_frame_end;
        state_reg == LMOC_ST_RUN && sq.enable && sq.nphase == nph_reg
            && cnt_reg == CNT_LAST && phase_reg == last_phase;
    endsequence
    property p_phase_bound;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == LMOC_ST_RUN |-> phase_reg < nph_reg;
    endproperty
    a_phase_bound: assert property (p_phase_bound) else $error("phase beyond mode");
    property p_pol_flip;
        @(posedge clk_i) disable iff (rst_i)
        s_frame_end |=> pol_reg != $past(pol_reg) && phase_reg == 2'h0 && start_reg;
    endproperty
    a_pol_flip: assert property (p_pol_flip) else $error("polarity not flipped");
endmodule : lmoc_phase_seq

//--- verilog/lmoc_output_ctrl.sv
// LCD multiplex output control: register slave, display register and drive levels
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "lmoc_consts.svh"
module lmoc_output_ctrl #(
    parameter int NSEG = `LMOC_SEGS,
    parameter int PHASE_CYCLES = `LMOC_PHASE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output lmoc_pkg::lmoc_level_t backplane_out_first_o,
    output lmoc_pkg::lmoc_level_t backplane_out_second_o,
    output lmoc_pkg::lmoc_level_t backplane_out_third_o,
    output lmoc_pkg::lmoc_level_t backplane_out_fourth_o,
    output lmoc_pkg::lmoc_level_t [NSEG-1:0] segment_outputs_o,
    output logic bias_bypass_o
);
    import lmoc_pkg::*;
    localparam int NBP = `LMOC_BPS;
    localparam int HIW = NSEG - 32;

    // Two bus words per RAM row: the logic cannot serve other widths
    if (NSEG < 33 || NSEG > 64) begin : g_chk
        $error("NSEG must lie between 33 and 64");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [3:0] mode_reg, mode_next;              // Enable, bias, drive mode
    logic bank_reg, bank_next;                    // Output bank select
    logic [NSEG-1:0] ram_reg [NBP];               // Display RAM, one word per row
    logic [NSEG-1:0] ram_next [NBP];
    logic ack_reg, ack_next;                      // Bus acknowledge
    logic [31:0] dat_reg, dat_next;               // Bus read data
    logic [NSEG-1:0] disp_reg, disp_next;         // Display register
    logic [1:0] dphase_reg, dphase_next;          // Phase held with display data
    logic dpol_reg, dpol_next;                    // Polarity held with display data
    lmoc_level_t bp_reg [NBP];                    // Backplane levels
    lmoc_level_t bp_next [NBP];
    lmoc_level_t [NSEG-1:0] seg_reg, seg_next;    // Segment levels
    logic bypass_reg, bypass_next;                // Divider bypass switch

    logic en;                                     // Display enabled
    logic half;                                   // Half bias selected
    lmoc_drive_t drv;                             // Drive mode
    logic wr_go;                                  // Write takes effect now
    logic [1:0] row_sel;                          // RAM row for next phase
    logic [3:0] rsel;                             // Row register index

    lmoc_seq_if sq();

    assign en = mode_reg[`LMOC_MODE_EN_BIT];
    assign half = mode_reg[`LMOC_MODE_BIAS_BIT];
    assign drv = lmoc_drive_t'(mode_reg[`LMOC_MODE_DRV_LSB +: 2]);
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
    assign rsel = 4'(wb_adr_i[7:2] - 6'(`LMOC_ADR_ROW_BASE >> 2));

    // Phase count per drive mode
    assign sq.enable = en;
    always_comb begin
        case (drv)
            LMOC_DRV_STATIC: sq.nphase = 3'h1;
            LMOC_DRV_MUX2: sq.nphase = 3'h2;
            LMOC_DRV_MUX3: sq.nphase = 3'h3;
            default: sq.nphase = 3'h4;
        endcase
    end

    lmoc_phase_seq #(
        .PHASE_CYCLES(PHASE_CYCLES)
    ) u_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sq(sq.seq)
    );

    // Byte-lane merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // Invert a level for the odd frame
    function automatic lmoc_level_t flip(input lmoc_level_t l, input logic p);
        return p ? ~l : l;
    endfunction : flip

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] mw;                          // Write word after byte-lane merge
        mw = 32'h0;
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        mode_next = mode_reg;
        bank_next = bank_reg;
        dat_next = dat_reg;
        for (int r = 0; r < NBP; r++) begin
            ram_next[r] = ram_reg[r];
        end
        // Read data captured as the answer is raised; unmapped reads zero
        if (ack_next) begin
            dat_next = 32'h0;
            if (wb_adr_i == `LMOC_ADR_MODE) begin
                dat_next = {28'h0, mode_reg};
            end else if (wb_adr_i == `LMOC_ADR_BANK) begin
                dat_next = {31'h0, bank_reg};
            end else if (wb_adr_i == `LMOC_ADR_STAT) begin
                dat_next = {28'h0, sq.pol, sq.phase, en};
            end else if (wb_adr_i >= `LMOC_ADR_ROW_BASE && wb_adr_i <= `LMOC_ADR_ROW_LAST) begin
                if (rsel[0]) begin
                    dat_next = 32'(ram_reg[rsel[2:1]][NSEG-1:32]);
                end else begin
                    dat_next = ram_reg[rsel[2:1]][31:0];
                end
            end
        end
        // Writes land on the edge where the acknowledge is seen
        if (wr_go) begin
            if (wb_adr_i == `LMOC_ADR_MODE) begin
                mw = merge({28'h0, mode_reg}, wb_dat_i, wb_sel_i);
                mode_next = mw[3:0];
            end else if (wb_adr_i == `LMOC_ADR_BANK) begin
                mw = merge({31'h0, bank_reg}, wb_dat_i, wb_sel_i);
                bank_next = mw[`LMOC_BANK_OUT_BIT];
            end else if (wb_adr_i >= `LMOC_ADR_ROW_BASE && wb_adr_i <= `LMOC_ADR_ROW_LAST) begin
                if (rsel[0]) begin
                    // Only the low lanes of the high word hold segments
                    mw = merge(32'(ram_reg[rsel[2:1]][NSEG-1:32]), wb_dat_i, wb_sel_i);
                    ram_next[rsel[2:1]][NSEG-1:32] = mw[HIW-1:0];
                end else begin
                    ram_next[rsel[2:1]][31:0] = merge(ram_reg[rsel[2:1]][31:0],
                                                      wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Display register: row for the starting phase
    // ----------------------------------------------------------------
    always_comb begin
        // Bank 1 shifts rows by two in static and 1:2 modes
        if (bank_reg && (drv == LMOC_DRV_STATIC || drv == LMOC_DRV_MUX2)) begin
            row_sel = 2'(sq.phase + 2'h2);
        end else begin
            row_sel = sq.phase;
        end
        disp_next = disp_reg;
        dphase_next = dphase_reg;
        dpol_next = dpol_reg;
        if (sq.start) begin
            disp_next = ram_reg[row_sel];
            dphase_next = sq.phase;
            dpol_next = sq.pol;
        end
    end

    // ----------------------------------------------------------------
    // Drive levels for backplanes and segments
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NBP; i++) begin : g_bp
        logic [1:0] idx;  // Phase this output serves
        always_comb begin
            case (drv)
                LMOC_DRV_STATIC: idx = 2'h0;
                LMOC_DRV_MUX2: idx = 2'(i % 2);
                LMOC_DRV_MUX3: idx = (i == 3) ? 2'h1 : 2'(i);
                default: idx = 2'(i);
            endcase
            if (!en) begin
                bp_next[i] = 2'h0;
            end else if (drv == LMOC_DRV_STATIC || idx == dphase_reg) begin
                bp_next[i] = flip(2'h3, dpol_reg);
            end else begin
                bp_next[i] = flip(2'h1, dpol_reg);
            end
        end
    end

    for (genvar s = 0; s < NSEG; s++) begin : g_seg
        always_comb begin
            if (!en) begin
                seg_next[s] = 2'h0;
            end else if (disp_reg[s]) begin
                seg_next[s] = flip(2'h0, dpol_reg);
            end else if (half || drv == LMOC_DRV_STATIC) begin
                seg_next[s] = flip(2'h3, dpol_reg);
            end else begin
                seg_next[s] = flip(2'h2, dpol_reg);
            end
        end
    end

    assign bypass_next = half;

    // ----------------------------------------------------------------
    // Register stage
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= `LMOC_MODE_RST;
            bank_reg <= `LMOC_BANK_RST;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
            disp_reg <= '0;
            dphase_reg <= 2'h0;
            dpol_reg <= 1'b0;
            seg_reg <= '0;
            bypass_reg <= 1'b0;
            for (int r = 0; r < NBP; r++) begin
                ram_reg[r] <= '0;
                bp_reg[r] <= 2'h0;
            end
        end else begin
            mode_reg <= mode_next;
            bank_reg <= bank_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            disp_reg <= disp_next;
            dphase_reg <= dphase_next;
            dpol_reg <= dpol_next;
            seg_reg <= seg_next;
            bypass_reg <= bypass_next;
            for (int r = 0; r < NBP; r++) begin
                ram_reg[r] <= ram_next[r];
                bp_reg[r] <= bp_next[r];
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign backplane_out_first_o = bp_reg[0];
    assign backplane_out_second_o = bp_reg[1];
    assign backplane_out_third_o = bp_reg[2];
    assign backplane_out_fourth_o = bp_reg[3];
    assign segment_outputs_o = seg_reg;
    assign bias_bypass_o = bypass_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_start_bank(logic b);
        sq.start && bank_reg == b && drv == LMOC_DRV_STATIC && sq.phase == 2'h0;
    endsequence
    property p_latch;
        sq.start |=> disp_reg == $past(ram_reg[row_sel]) ##1 $stable(disp_reg) [*3];
    endproperty
    a_latch: assert property (p_latch or (##[1:4] sq.start)) else $error("display latch");
    property p_bank1;
        s_start_bank(1'b1) |=> disp_reg == $past(ram_reg[2]);
    endproperty
    a_bank1: assert property (p_bank1) else $error("bank 1 row not shown");
    property p_mux3;
        en && drv == LMOC_DRV_MUX3 && $stable(mode_reg) |=> bp_reg[3] == bp_reg[1];
    endproperty
    a_mux3: assert property (p_mux3) else $error("fourth differs from second");
    property p_mux2;
        en && drv == LMOC_DRV_MUX2 && $stable(mode_reg)
            |=> bp_reg[0] == bp_reg[2] && bp_reg[1] == bp_reg[3];
    endproperty
    a_mux2: assert property (p_mux2) else $error("paired backplanes differ");
    property p_static;
        en && drv == LMOC_DRV_STATIC |=> bp_reg[0] == bp_reg[1] && bp_reg[1] == bp_reg[2]
            && bp_reg[2] == bp_reg[3] && bp_reg[0] == flip(2'h3, $past(dpol_reg));
    endproperty
    a_static: assert property (p_static) else $error("static backplanes differ");
    property p_seg_on;
        en && disp_reg[0] |=> seg_reg[0] == flip(2'h0, $past(dpol_reg));
    endproperty
    a_seg_on: assert property (p_seg_on) else $error("segment on level");
    property p_bypass;
        wr_go && wb_adr_i == `LMOC_ADR_MODE && wb_sel_i[0]
            |=> ##1 bias_bypass_o == $past(wb_dat_i[`LMOC_MODE_BIAS_BIT], 2);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass switch wrong");
    property p_active_bp;
        en && drv == LMOC_DRV_MUX4 && $stable(mode_reg) && dphase_reg == 2'h2
            |=> bp_reg[2] == flip(2'h3, $past(dpol_reg)) && bp_reg[0] != bp_reg[2];
    endproperty
    a_active_bp: assert property (p_active_bp) else $error("active backplane");
endmodule : lmoc_output_ctrl

//--- tb/lmoc_host_model.sv
// Host model: Wishbone master that runs the display bring-up sequence
`timescale 1ns/1ps
`include "lmoc_consts.svh"
module lmoc_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    // Display rows prepared by the host, row r at index r
    logic [39:0] rows [4] = '{40'hf00fa55ac3, 40'h3c96690ff1, 40'h123456789a, 40'hedcba98765};
    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    // Bus idle from time zero, so the slave sees a clean start
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // One classic cycle; returns at the edge where ack is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask : xfer
    // Mode with display off, rows from row 0 up, bank, then display on
    task automatic bring_up(input logic [1:0] drv, input logic half, input logic bank);
        logic [31:0] q;
        xfer(1'b1, `LMOC_ADR_MODE, {28'h0, drv, half, 1'b0}, q);
        for (int r = 0; r < 4; r++) begin
            xfer(1'b1, `LMOC_ADR_ROW_BASE + 8'(8 * r), rows[r][31:0], q);
            xfer(1'b1, `LMOC_ADR_ROW_BASE + 8'(8 * r + 4), {24'h0, rows[r][39:32]}, q);
        end
        // Blinking stays off, as no blink control exists here
        xfer(1'b1, `LMOC_ADR_BANK, {31'h0, bank}, q);
        xfer(1'b1, `LMOC_ADR_MODE, {28'h0, drv, half, 1'b1}, q);
    endtask : bring_up
endmodule : lmoc_host_model

//--- tb/lmoc_output_ctrl_bench.sv
// Self-checking bench of the LCD multiplex output control block
`timescale 1ns/1ps
`include "lmoc_consts.svh"
`define LMOC_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module lmoc_output_ctrl_bench;
    import lmoc_pkg::*;
    localparam int P = 8; // Short phase for simulation
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic ack, bypass;
    lmoc_level_t bp [4];
    lmoc_level_t [39:0] seg;
    int fails = 0;
    int cmp_count = 0;
    // Clock of 4 ns
    always #2 clk_i = ~clk_i;
    lmoc_output_ctrl #(.NSEG(40), .PHASE_CYCLES(P)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .backplane_out_first_o(bp[0]), .backplane_out_second_o(bp[1]),
        .backplane_out_third_o(bp[2]), .backplane_out_fourth_o(bp[3]),
        .segment_outputs_o(seg), .bias_bypass_o(bypass));
    lmoc_host_model i_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    // Counts and verdict
    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // Outputs dark when off; reset values, unmapped place, row read-back
    task automatic check_off(input logic regs);
        #1;
        for (int b = 0; b < 4; b++) `LMOC_CHK(bp[b], 2'h0)
        `LMOC_CHK(seg, 80'h0)
        if (regs) begin
            `LMOC_CHK(bypass, 1'b0)
            i_host.xfer(1'b0, `LMOC_ADR_MODE, 32'h0, q);
            `LMOC_CHK(q, 32'h0)
            i_host.xfer(1'b0, `LMOC_ADR_STAT, 32'h0, q);
            `LMOC_CHK(q, 32'h0)
            i_host.xfer(1'b1, 8'h40, 32'hffffffff, q);
            i_host.xfer(1'b0, 8'h40, 32'h0, q);
            `LMOC_CHK(q, 32'h0)
            i_host.xfer(1'b1, `LMOC_ADR_ROW_BASE, 32'h89abcdef, q);
            i_host.xfer(1'b0, `LMOC_ADR_ROW_BASE, 32'h0, q);
            `LMOC_CHK(q, 32'h89abcdef)
        end
        $display("Test off state done");
    endtask : check_off
    // Bring up one mode and follow two whole frames phase by phase
    task automatic run_mode(input logic [1:0] drv, input logic half, input logic bank);
        int n;
        int row;
        logic pol;
        lmoc_level_t eb, es;
        n = int'(drv) + 1;
        i_host.bring_up(drv, half, bank);
        repeat (4) @(posedge clk_i);
        for (int k = 0; k < 2 * n; k++) begin
            #1;
            pol = ((k / n) % 2) == 1;
            `LMOC_CHK(bypass, half)
            for (int b = 0; b < 4; b++) begin
                eb = ((((n == 3) && (b == 3)) ? 1 : b % n) == k % n) ? 2'h3 : 2'h1;
                `LMOC_CHK(bp[b], pol ? 2'h3 - eb : eb)
            end
            row = k % n + ((bank && n <= 2) ? 2 : 0);
            for (int s = 0; s < 40; s++) begin
                es = i_host.rows[row][s] ? 2'h0 : ((half || n == 1) ? 2'h3 : 2'h2);
                `LMOC_CHK(seg[s], pol ? 2'h3 - es : es)
            end
            repeat (P) @(posedge clk_i);
        end
        $display("Test mode %0d bias %0b bank %0b done", drv, half, bank);
    endtask : run_mode
    // Main sequence: off-state checks follow reset, then bring-up of each mode
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check_off(1'b1);
        run_mode(LMOC_DRV_STATIC, 1'b0, 1'b0);
        run_mode(LMOC_DRV_STATIC, 1'b0, 1'b1);
        run_mode(LMOC_DRV_MUX2, 1'b1, 1'b0);
        run_mode(LMOC_DRV_MUX2, 1'b0, 1'b1);
        run_mode(LMOC_DRV_MUX3, 1'b1, 1'b0);
        run_mode(LMOC_DRV_MUX3, 1'b0, 1'b0);
        run_mode(LMOC_DRV_MUX4, 1'b0, 1'b0);
        run_mode(LMOC_DRV_MUX4, 1'b1, 1'b1);
        i_host.xfer(1'b1, `LMOC_ADR_MODE, 32'h0, q);
        repeat (4) @(posedge clk_i);
        check_off(1'b0);
        wrap_up();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #80000;
        fails++;
        wrap_up();
    end
endmodule : lmoc_output_ctrl_bench
